// [rtl/pc_pkg.sv]
/*
 * Shared constants and types of the PLL routing and control pin block:
 * register offsets, field positions, reset bytes, source codes and pin modes.
 * Assumes byte-wide registers reached through a plain strobe port.
 */
package pc_pkg;

	// ----------------------------------------------------------------
	// register port geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int NUM_REGS = 27;
	localparam int NUM_PLL = 3;
	localparam int NUM_DIV = 6;

	// ----------------------------------------------------------------
	// offsets
	// ----------------------------------------------------------------
	localparam logic [4:0] OFS_IDENT = 5'h00;
	localparam logic [4:0] OFS_LAST = 5'h1A;
	localparam int OFS_PLL_BASE = 1;
	localparam int PLL_STRIDE = 3;
	localparam int OFS_BYPASS = 3;
	localparam int OFS_RANGE = 6;
	localparam int OFS_SRC_P0 = 9;
	localparam int OFS_PIN_CFG = 10;
	localparam int OFS_INPUT_CFG = 11;
	localparam int OFS_PD_CFG = 12;
	localparam int OFS_DIV_BASE = 13;
	localparam int OFS_SSC_CFG = 25;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int POS_PLL_FLAG = 5;
	localparam int POS_M_MSB = 4;
	localparam int POS_PIN0_MODE = 0;
	localparam int POS_PIN1_MODE = 2;
	localparam int POS_CLKSEL = 4;
	localparam int POS_SRC_HI = 5;
	localparam int POS_SRC_MID = 3;
	localparam int POS_SRC_LO = 0;
	localparam int POS_INPUT_SRC = 6;
	localparam int POS_PD = 6;
	localparam int POS_SSC_MODE = 4;

	// ssc modulation code that means spread bypassed
	localparam logic [2:0] SSC_BYPASS = 3'h0;

	// identification byte, values arbitrary
	localparam logic [3:0] REVISION_CODE = 4'h0;
	localparam logic [3:0] VENDOR_CODE = 4'hA;

	// ----------------------------------------------------------------
	// power-up contents of every byte
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_RESET [0:NUM_REGS-1] = '{
		8'h00, 8'h01, 8'h08, 8'h00, 8'h1B, 8'hFA, 8'hE0, 8'h77, 8'h40, 8'h5C,
		8'h80, 8'h09, 8'h09, 8'h0A, 8'h14, 8'h08, 8'h09, 8'h20, 8'h04,
		8'h3A, 8'h3A, 8'h3A, 8'h3A, 8'h3A, 8'h3A, 8'h00, 8'h00};

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PC_SRC_INPUT = 3'h0,
		PC_SRC_PLL1 = 3'h1,
		PC_SRC_PLL2 = 3'h2,
		PC_SRC_PLL2_SSC = 3'h3,
		PC_SRC_PLL3 = 3'h4
	} pc_src_e;

	typedef enum logic [1:0] {
		PC_P0_POWERDOWN = 2'h0,
		PC_P0_TESTBYPASS = 2'h1,
		PC_P0_CLKSEL = 2'h2,
		PC_P0_ADDR = 2'h3
	} pc_pin0_mode_e;

	typedef enum logic [1:0] {
		PC_P1_LOW = 2'h0,
		PC_P1_HIZ = 2'h1,
		PC_P1_RSVD = 2'h2,
		PC_P1_ADDR = 2'h3
	} pc_pin1_mode_e;

	localparam logic [1:0] INPUT_LVCMOS = 2'h1;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic vco_bypass_select;
		logic vco_range_select;
		logic [8:0] ref_div;
		logic [11:0] fb_div;
	} pc_pll_s;

	typedef struct packed {
		logic pll_pd;
		logic input_pd;
		logic out_hiz;
		logic out_inactive;
		logic div_bypass;
		logic clk_in_sel;
		logic slave_addr_bit_zero_en;
		logic slave_addr_bit_zero;
		logic slave_addr_bit_one_en;
		logic slave_addr_bit_one;
	} pc_pins_s;

endpackage

// [rtl/pc_pin_decode.sv]
/*
 * Combinational decode of the two control pins under their configured modes.
 * Assumes pin levels are synchronous to the caller's clock.
 */
`timescale 1ns/100ps
module pc_pin_decode
(
	input wire logic control_pin_zero,
	input wire logic control_pin_one,
	input wire logic [1:0] pin0_mode,
	input wire logic [1:0] pin1_mode,
	input wire logic clksel_reg,
	input wire logic [1:0] input_src,
	input wire logic pd_reg,
	output pc_pkg::pc_pins_s pins
);

	// ----------------------------------------------------------------
	// pin interpretation
	// ----------------------------------------------------------------
	always_comb
	begin
		pins = '0;
		pins.pll_pd = pd_reg;
		pins.input_pd = pd_reg;
		pins.clk_in_sel = clksel_reg;
		unique case (pc_pkg::pc_pin0_mode_e'(pin0_mode))
			pc_pkg::PC_P0_POWERDOWN:
			begin
				if (!control_pin_zero)
				begin
					pins.pll_pd = 1'b1;
					pins.input_pd = 1'b1;
				end
			end
			pc_pkg::PC_P0_TESTBYPASS:
			begin
				if (!control_pin_zero)
				begin
					pins.div_bypass = 1'b1;
					pins.pll_pd = 1'b1;
				end
			end
			pc_pkg::PC_P0_CLKSEL:
			begin
				// only two single-ended inputs can be swapped by the pin
				if (input_src == pc_pkg::INPUT_LVCMOS)
					pins.clk_in_sel = control_pin_zero;
			end
			pc_pkg::PC_P0_ADDR:
			begin
				pins.slave_addr_bit_zero_en = 1'b1;
				pins.slave_addr_bit_zero = control_pin_zero;
			end
		endcase
		unique case (pc_pkg::pc_pin1_mode_e'(pin1_mode))
			pc_pkg::PC_P1_LOW: pins.out_inactive = !control_pin_one;
			pc_pkg::PC_P1_HIZ: pins.out_hiz = !control_pin_one;
			pc_pkg::PC_P1_RSVD: pins.out_inactive = 1'b0;
			pc_pkg::PC_P1_ADDR:
			begin
				pins.slave_addr_bit_one_en = 1'b1;
				pins.slave_addr_bit_one = control_pin_one;
			end
		endcase
		// power-down owns the outputs: high impedance, never a forced level
		if (pins.input_pd)
		begin
			pins.out_hiz = 1'b1;
			pins.out_inactive = 1'b0;
		end
	end

endmodule

// [rtl/pc_src_route.sv]
/*
 * Per-divider source resolution of the five-by-six switch.
 * Assumes raw three-bit source fields straight from the configuration bytes.
 */
`timescale 1ns/100ps
module pc_src_route
(
	input wire logic [5:0][2:0] src_field,
	input wire logic div_bypass,
	input wire logic ssc_off,
	output logic [5:0][2:0] src_eff,
	output logic [5:0] div_idle
);

	// ----------------------------------------------------------------
	// one selector per post-divider
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < pc_pkg::NUM_DIV; i++)
		begin : g_div
			// reserved codes park the divider rather than guess a source
			always_comb
			begin
				src_eff[i] = src_field[i];
				div_idle[i] = (src_field[i] > pc_pkg::PC_SRC_PLL3);
				if (div_bypass)
				begin
					src_eff[i] = pc_pkg::PC_SRC_INPUT;
					div_idle[i] = 1'b0;
				end
				else if (ssc_off && src_field[i] == pc_pkg::PC_SRC_PLL2_SSC)
					div_idle[i] = 1'b1;
			end
		end
	endgenerate

endmodule

// [rtl/pc_routing_ctl.sv]
/*
 * Top of the PLL routing and control pin block: byte register file on a
 * plain strobe port, field extraction, pin decode and source routing, with
 * every result held in output flip-flops.
 * Assumes a strobe master that never asserts read and write together, and
 * control pins already synchronous to clk.
 */
// Chosen here: the register offsets and strobed register access.
// Summary of operation
// - per-PLL bypass bit, 0 passes the VCO, 1 routes the bypass; default 0
// - per-PLL range bit, 0 normal speed, 1 high speed; high speed after reset
// - feedback dividers reset to 8, 250 and 3136
// - divider source codes 0..4 pick input, PLL1, PLL2, PLL2 spread, PLL3
// - spread bypass powers spread logic down and holds spread output low
// - pin-zero mode 00, low pin powers down and floats outputs
// - pin-zero mode 01, low pin bypasses PLL and dividers, outputs active
// - pin-zero mode 10, pin overrides the input clock select bit
// - pin clock select ignored for crystal or differential input
// - pin-zero mode 11, pin supplies slave address bit zero
// - address use of a pin starts right after its byte is written
// - pin-zero power-down beats pin-one low or high impedance forcing
// - pin-one mode 00, low pin forces outputs to inactive level
// - pin-one mode 01, low pin floats outputs; mode 10 reserved
// - pin-one mode 11, pin supplies slave address bit one
`timescale 1ns/100ps
module pc_routing_ctl
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic control_pin_zero,
	input wire logic control_pin_one,
	output logic [7:0] reg_rdata,
	output pc_pkg::pc_pll_s [2:0] pll_cfg,
	output logic [5:0][2:0] div_src,
	output logic [5:0][6:0] div_ratio,
	output logic [5:0] div_idle,
	output pc_pkg::pc_pins_s pin_ctl,
	output logic ssc_pd,
	output logic ssc_out_low
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [7:0] regs [0:pc_pkg::NUM_REGS-1];
	logic [7:0] next_regs [0:pc_pkg::NUM_REGS-1];
	logic [7:0] next_reg_rdata;
	pc_pkg::pc_pll_s [2:0] cur_pll;
	pc_pkg::pc_pll_s [2:0] next_pll_cfg;
	logic [5:0][2:0] src_field;
	logic [5:0][2:0] src_eff;
	logic [5:0][6:0] next_div_ratio;
	logic [5:0] idle_eff;
	logic [5:0][2:0] next_div_src;
	logic [5:0] next_div_idle;
	pc_pkg::pc_pins_s pins_eff;
	pc_pkg::pc_pins_s next_pin_ctl;
	logic ssc_off;
	logic next_ssc_pd;
	logic next_ssc_out_low;
	logic addr_ok;

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------

	// byte zero is read-only, everything above it up to the last byte is storage
	assign addr_ok = (reg_addr != pc_pkg::OFS_IDENT) && (reg_addr <= pc_pkg::OFS_LAST);

	// a write lands in one edge, so the next edge already routes with it
	always_comb
	begin
		next_regs = regs;
		if (reg_wr && addr_ok)
			next_regs[reg_addr] = reg_wdata;
	end

	// power-up image comes from the package table
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			regs <= pc_pkg::REG_RESET;
		else
			regs <= next_regs;
	end

	// read data stand only in the cycle after the strobe; unmapped reads zero
	always_comb
	begin
		next_reg_rdata = 8'h00;
		if (reg_rd)
		begin
			if (reg_addr == pc_pkg::OFS_IDENT)
				next_reg_rdata = {pc_pkg::REVISION_CODE, pc_pkg::VENDOR_CODE};
			else if (addr_ok)
				next_reg_rdata = regs[reg_addr];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= next_reg_rdata;
	end

	// ----------------------------------------------------------------
	// field extraction
	// ----------------------------------------------------------------

	// each PLL owns three consecutive bytes; flag bits share bytes 3 and 6
	genvar k;
	generate
		for (k = 0; k < pc_pkg::NUM_PLL; k++)
		begin : g_pll
			localparam int BASE = pc_pkg::OFS_PLL_BASE + pc_pkg::PLL_STRIDE * k;
			assign cur_pll[k].vco_bypass_select = regs[pc_pkg::OFS_BYPASS][pc_pkg::POS_PLL_FLAG + k];
			assign cur_pll[k].vco_range_select = regs[pc_pkg::OFS_RANGE][pc_pkg::POS_PLL_FLAG + k];
			assign cur_pll[k].ref_div = {regs[BASE + 2][pc_pkg::POS_M_MSB], regs[BASE]};
			assign cur_pll[k].fb_div = {regs[BASE + 2][3:0], regs[BASE + 1]};
		end
	endgenerate

	// source fields of the six post-dividers
	assign src_field[0] = regs[pc_pkg::OFS_SRC_P0][pc_pkg::POS_SRC_HI +: 3];
	assign src_field[1] = regs[pc_pkg::OFS_PIN_CFG][pc_pkg::POS_SRC_HI +: 3];
	assign src_field[2] = regs[pc_pkg::OFS_INPUT_CFG][pc_pkg::POS_SRC_LO +: 3];
	assign src_field[3] = regs[pc_pkg::OFS_INPUT_CFG][pc_pkg::POS_SRC_MID +: 3];
	assign src_field[4] = regs[pc_pkg::OFS_PD_CFG][pc_pkg::POS_SRC_LO +: 3];
	assign src_field[5] = regs[pc_pkg::OFS_PD_CFG][pc_pkg::POS_SRC_MID +: 3];

	// spread circuitry is off whenever its modulation field asks for bypass
	assign ssc_off = (regs[pc_pkg::OFS_SSC_CFG][pc_pkg::POS_SSC_MODE +: 3] == pc_pkg::SSC_BYPASS);

	// ----------------------------------------------------------------
	// pin decode and source routing
	// ----------------------------------------------------------------
	pc_pin_decode u_pins
	(
		.control_pin_zero(control_pin_zero),
		.control_pin_one(control_pin_one),
		.pin0_mode(regs[pc_pkg::OFS_PIN_CFG][pc_pkg::POS_PIN0_MODE +: 2]),
		.pin1_mode(regs[pc_pkg::OFS_PIN_CFG][pc_pkg::POS_PIN1_MODE +: 2]),
		.clksel_reg(regs[pc_pkg::OFS_PIN_CFG][pc_pkg::POS_CLKSEL]),
		.input_src(regs[pc_pkg::OFS_INPUT_CFG][pc_pkg::POS_INPUT_SRC +: 2]),
		.pd_reg(regs[pc_pkg::OFS_PD_CFG][pc_pkg::POS_PD]),
		.pins(pins_eff)
	);

	pc_src_route u_route
	(
		.src_field(src_field),
		.div_bypass(pins_eff.div_bypass),
		.ssc_off(ssc_off),
		.src_eff(src_eff),
		.div_idle(idle_eff)
	);

	// ----------------------------------------------------------------
	// output stage
	// ----------------------------------------------------------------

	// next values of all configuration outputs; test bypass also
	// neutralises the PLL path so a test sees the raw input clock
	always_comb
	begin
		next_pll_cfg = cur_pll;
		for (int i = 0; i < pc_pkg::NUM_PLL; i++)
		begin
			if (pins_eff.div_bypass)
				next_pll_cfg[i].vco_bypass_select = 1'b1;
		end
		for (int j = 0; j < pc_pkg::NUM_DIV; j++)
			next_div_ratio[j] = regs[pc_pkg::OFS_DIV_BASE + j][6:0];
		next_div_src = src_eff;
		next_div_idle = idle_eff;
		next_pin_ctl = pins_eff;
		next_ssc_pd = ssc_off || pins_eff.pll_pd;
		next_ssc_out_low = ssc_off;
	end

	// outputs are all flops; during reset they are held at zero
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pll_cfg <= '0;
			div_src <= '0;
			div_ratio <= '0;
			div_idle <= '0;
			pin_ctl <= '0;
			ssc_pd <= 1'b0;
			ssc_out_low <= 1'b0;
		end
		else
		begin
			pll_cfg <= next_pll_cfg;
			div_src <= next_div_src;
			div_ratio <= next_div_ratio;
			div_idle <= next_div_idle;
			pin_ctl <= next_pin_ctl;
			ssc_pd <= next_ssc_pd;
			ssc_out_low <= next_ssc_out_low;
		end
	end

endmodule

// [sim/pc_routing_chk.sv]
/*
 * Port-level properties of the routing block, built over a shadow of bytes 10, 11, 12, 25.
 * Assumes binding to pc_routing_ctl with matching port names.
 */
`timescale 1ns/100ps
module pc_routing_chk
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic control_pin_zero,
	input wire logic control_pin_one,
	input wire logic [7:0] reg_rdata,
	input wire pc_pkg::pc_pll_s [2:0] pll_cfg,
	input wire logic [5:0][2:0] div_src,
	input wire pc_pkg::pc_pins_s pin_ctl,
	input wire logic ssc_pd,
	input wire logic ssc_out_low
);
	// ----------------------------------------------------------------
	// shadow bytes
	// ----------------------------------------------------------------
	logic [7:0] b10, b11, b12, b25;
	logic pd_any, sel_exp, a0_en, a1_en, ssc_off;
	logic live;
	default clocking cb @(posedge clk); endclocking
	// the edge that releases reset still loads zeros into the outputs, so attempts begin one edge later
	default disable iff (!rst_n || !live);
	always_ff @(posedge clk)
	begin
		live <= rst_n;
	end
	// mirrors host writes so properties know the live modes
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			b10 <= pc_pkg::REG_RESET[10];
			b11 <= pc_pkg::REG_RESET[11];
			b12 <= pc_pkg::REG_RESET[12];
			b25 <= pc_pkg::REG_RESET[25];
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				5'h0A: b10 <= reg_wdata;
				5'h0B: b11 <= reg_wdata;
				5'h0C: b12 <= reg_wdata;
				5'h19: b25 <= reg_wdata;
				default: ;
			endcase
		end
	end
	// expected decode from shadow and pins
	assign pd_any = (b10[1:0] == 2'h0 && !control_pin_zero) || b12[6];
	assign sel_exp = (b10[1:0] == 2'h2) ? control_pin_zero : b10[4];
	assign a0_en = b10[1:0] == 2'h3;
	assign a1_en = b10[3:2] == 2'h3;
	assign ssc_off = b25[6:4] == pc_pkg::SSC_BYPASS;
	sequence cfg_read;
		reg_rd && reg_addr == 5'h0A;
	endsequence
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
	cfg_echo_a: assert property (cfg_read |=> reg_rdata == b10) else $error("pin byte readback");
	pd_force_a: assert property (pd_any |=> pin_ctl.pll_pd && pin_ctl.input_pd && pin_ctl.out_hiz
		&& !pin_ctl.out_inactive) else $error("power-down not forced");
	test_byp_a: assert property (b10[1:0] == 2'h1 && !control_pin_zero && !b12[6] |=> pin_ctl.div_bypass
		&& pin_ctl.pll_pd && !pin_ctl.out_hiz && div_src == '0) else $error("test bypass wrong");
	clk_sel_a: assert property (b11[7:6] == 2'h1 |=> pin_ctl.clk_in_sel == $past(sel_exp))
		else $error("clock select wrong");
	clk_keep_a: assert property (b11[7:6] != 2'h1 |=> pin_ctl.clk_in_sel == $past(b10[4]))
		else $error("clock select leaked");
	addr_zero_a: assert property (1 |=> pin_ctl.slave_addr_bit_zero_en == $past(a0_en)
		&& (!$past(a0_en) || pin_ctl.slave_addr_bit_zero == $past(control_pin_zero))) else $error("addr bit 0");
	addr_one_a: assert property (1 |=> pin_ctl.slave_addr_bit_one_en == $past(a1_en)
		&& (!$past(a1_en) || pin_ctl.slave_addr_bit_one == $past(control_pin_one))) else $error("addr bit 1");
	out_low_a: assert property (!pd_any && b10[3:2] == 2'h0 && !control_pin_one
		|=> pin_ctl.out_inactive && !pin_ctl.out_hiz) else $error("outputs not low");
	out_float_a: assert property (!pd_any && b10[3:2] == 2'h1 && !control_pin_one
		|=> pin_ctl.out_hiz && !pin_ctl.out_inactive) else $error("outputs not floated");
	out_act_a: assert property (!pd_any && control_pin_one |=> !pin_ctl.out_hiz && !pin_ctl.out_inactive)
		else $error("outputs not active");
	spread_off_a: assert property (1 |=> ssc_out_low == $past(ssc_off) && (!$past(ssc_off) || ssc_pd))
		else $error("spread state wrong");
endmodule
bind pc_routing_ctl pc_routing_chk chk_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .control_pin_zero(control_pin_zero), .control_pin_one(control_pin_one),
	.reg_rdata(reg_rdata), .pll_cfg(pll_cfg), .div_src(div_src), .pin_ctl(pin_ctl), .ssc_pd(ssc_pd),
	.ssc_out_low(ssc_out_low));

// [sim/pc_host.sv]
/*
 * Configuring host on the register port: one-cycle strobes after a rising edge.
 * Assumes a slave that never stalls and answers reads one cycle later.
 */
`timescale 1ns/100ps
module pc_host
(
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output logic [4:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	initial
	begin
		reg_addr = 5'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// released lines show the inverse so stale values are never trusted
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [7:0] q);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		q = reg_rdata;
	endtask
endmodule

// [sim/testbench.sv]
/*
 * Self-checking bench of the routing block: host writes, pin moves, compares.
 * Assumes pc_pkg, the design and the host model are compiled first.
 */
`timescale 1ns/100ps
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic control_pin_zero = 1'b1;
	logic control_pin_one = 1'b1;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, q;
	logic reg_wr, reg_rd, ssc_pd, ssc_out_low;
	pc_pkg::pc_pll_s [2:0] pll_cfg;
	logic [5:0][2:0] div_src;
	logic [5:0][6:0] div_ratio;
	logic [5:0] div_idle;
	pc_pkg::pc_pins_s pin_ctl;
	int num_errors = 0;
	int num_checks = 0;
	always #12.5 clk = ~clk;
	pc_host host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd));
	pc_routing_ctl dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .control_pin_zero(control_pin_zero), .control_pin_one(control_pin_one),
		.reg_rdata(reg_rdata), .pll_cfg(pll_cfg), .div_src(div_src), .div_ratio(div_ratio), .div_idle(div_idle),
		.pin_ctl(pin_ctl), .ssc_pd(ssc_pd), .ssc_out_low(ssc_out_low));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one edge: derived outputs follow a write or a pin move by exactly one cycle
	task automatic settle;
		@(posedge clk);
		#1;
	endtask
	task automatic pins(input logic p0, input logic p1);
		@(posedge clk);
		control_pin_zero <= p0;
		control_pin_one <= p1;
		settle;
	endtask
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		settle;
		for (int k = 0; k < 3; k++)
		begin
			chk("vco bypass", pll_cfg[k].vco_bypass_select, 1'h0);
			chk("vco range", pll_cfg[k].vco_range_select, 1'h1);
		end
		chk("fb div 1", pll_cfg[0].fb_div, 12'h008);
		chk("fb div 2", pll_cfg[1].fb_div, 12'h0FA);
		chk("fb div 3", pll_cfg[2].fb_div, 12'hC40);
		chk("ref divs", {pll_cfg[2].ref_div, pll_cfg[1].ref_div, pll_cfg[0].ref_div}, {9'h177, 9'h01B, 9'h001});
		for (int j = 0; j < 6; j++)
			chk("div ratio", div_ratio[j], pc_pkg::REG_RESET[pc_pkg::OFS_DIV_BASE + j][6:0]);
		chk("sources", div_src, {3'h1, 3'h1, 3'h1, 3'h1, 3'h4, 3'h2});
		chk("spread low", ssc_out_low, 1'h1);
		chk("pll pd", pin_ctl.pll_pd, 1'h0);
		host_u.rd(5'h0A, q);
		chk("byte 10", q, 8'h80);
		$display("test defaults done");
		// every source code on P0, spread bypassed
		for (int c = 0; c < 8; c++)
		begin
			host_u.wr(5'h09, {c[2:0], 5'h1C});
			settle;
			chk("p0 source", div_src[0], c[2:0]);
			chk("p0 idle", div_idle[0], c >= 5 || c == 3);
		end
		// park P0 on the spread source before switching the spread on
		host_u.wr(5'h09, 8'h7C);
		host_u.wr(5'h19, 8'h10);
		settle;
		chk("spread on", ssc_out_low, 1'h0);
		chk("spread up", ssc_pd, 1'h0);
		chk("p0 spread src", div_src[0], 3'h3);
		chk("p0 idle on", div_idle[0], 1'h0);
		host_u.wr(5'h19, 8'h00);
		host_u.wr(5'h09, 8'h5C);
		settle;
		chk("spread pd", ssc_pd, 1'h1);
		$display("test sources done");
		// legal dividers only, range bit set for the upper band
		host_u.wr(5'h03, 8'hA0);
		host_u.wr(5'h06, 8'h40);
		host_u.wr(5'h02, 8'h20);
		settle;
		chk("bypass", {pll_cfg[2].vco_bypass_select, pll_cfg[1].vco_bypass_select,
			pll_cfg[0].vco_bypass_select}, 3'h5);
		chk("range", {pll_cfg[2].vco_range_select, pll_cfg[1].vco_range_select,
			pll_cfg[0].vco_range_select}, 3'h2);
		chk("fb new", pll_cfg[0].fb_div, 12'h020);
		host_u.wr(5'h03, 8'h00);
		host_u.wr(5'h06, 8'hE0);
		$display("test pll done");
		// pin zero modes
		pins(1'b0, 1'b0);
		chk("pd hiz", pin_ctl.out_hiz, 1'h1);
		chk("pd low", pin_ctl.out_inactive, 1'h0);
		host_u.wr(5'h0A, 8'h81);
		pins(1'b0, 1'b1);
		chk("tb bypass", pin_ctl.div_bypass, 1'h1);
		chk("tb active", pin_ctl.out_hiz, 1'h0);
		chk("tb src", div_src, 18'h00000);
		host_u.wr(5'h0B, 8'h49);
		host_u.wr(5'h0A, 8'h82);
		pins(1'b1, 1'b1);
		chk("sel pin", pin_ctl.clk_in_sel, 1'h1);
		host_u.wr(5'h0B, 8'h09);
		settle;
		chk("sel crystal", pin_ctl.clk_in_sel, 1'h0);
		host_u.wr(5'h0A, 8'h83);
		settle;
		chk("a0 en", pin_ctl.slave_addr_bit_zero_en, 1'h1);
		pins(1'b0, 1'b1);
		chk("a0", pin_ctl.slave_addr_bit_zero, 1'h0);
		$display("test pin zero done");
		// pin one modes, pin zero high
		pins(1'b1, 1'b0);
		for (int m = 0; m < 3; m++)
		begin
			host_u.wr(5'h0A, 8'h80 | (m[7:0] << 2));
			settle;
			chk("inactive", pin_ctl.out_inactive, m == 0);
			chk("hiz", pin_ctl.out_hiz, m == 1);
		end
		host_u.wr(5'h0A, 8'h8C);
		pins(1'b1, 1'b1);
		chk("a1", {pin_ctl.slave_addr_bit_one_en, pin_ctl.slave_addr_bit_one}, 2'h3);
		host_u.wr(5'h0A, 8'h80);
		pins(1'b1, 1'b0);
		host_u.wr(5'h0C, 8'h49);
		settle;
		chk("reg pd", {pin_ctl.pll_pd, pin_ctl.out_hiz, pin_ctl.out_inactive}, 3'h6);
		$display("test pin one done");
		// writes to byte zero and outside the map are ignored
		host_u.wr(5'h00, 8'h55);
		host_u.wr(5'h1B, 8'h55);
		host_u.rd(5'h00, q);
		chk("ident", q, {pc_pkg::REVISION_CODE, pc_pkg::VENDOR_CODE});
		host_u.rd(5'h1B, q);
		chk("unmapped", q, 8'h00);
		$display("test map done");
		tally_and_finish;
	end
	// the tests need well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		num_errors++;
		tally_and_finish;
	end
endmodule
